// *** shared/spo_pkg.sv ***
// What this block does
// - after power-up, master-enabled port goes to fabric
// - jtag flash programming or service reclaims port
// - controller drives only dedicated flash pins
// - every finished service returns 8-bit status
// - codes 1, 4, 8 for hash, header, sequence
// - code 2 for data after end component
// - code 3 key fault, code 6 mode forbidden
// - code 5 when back level not met
// - codes 7, 9, 10 for binding mismatches
// - code 11 protocol, code 12 verify forbidden
// - code 13 certificate, code 14 integrity bits
// - code 21 when not serial master
// - codes 22, 23 for no valid image
// - code 24 newer design; 25 never produced
// - code 26 invalid image, 27 recovery failed
// - code 127 abort on foreign instruction
// - codes 128, 131 for verify failures
// - code 129 protected, code 130 mode disabled
// - code 132 hardware fault, 133 payload error
// - code 134 hv failure, 135 hv state
// - enable pin low tri-states all port outputs
package spo_pkg;
    // port owner encoding, gray along the usual path
    typedef enum logic [1:0] {
        SPO_OWN_NONE = 2'h0,
        SPO_OWN_CTRL = 2'h1,
        SPO_OWN_FAB  = 2'h3,
        SPO_OWN_JTAG = 2'h2
    } spo_owner_e;

    // fault causes, one-hot index into the cause vector
    localparam int unsigned SPO_NCAUSE = 27;
    localparam logic [7:0] SPO_ST_OK        = 8'h00;
    localparam logic [7:0] SPO_ST_RESERVED  = 8'h19;
    // status codes in cause-index order, priority lowest index first
    localparam logic [7:0] SPO_CODE [SPO_NCAUSE] = '{
        8'h01, 8'h02, 8'h03, 8'h04,
        8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0a, 8'h0b, 8'h0c,
        8'h0d, 8'h0e, 8'h15, 8'h16,
        8'h17, 8'h18, 8'h1a, 8'h1b,
        8'h7f, 8'h80, 8'h81, 8'h82,
        8'h83, 8'h84, 8'h85
    };
    // codes 134, 135 sit past the table end in the cause vector
    localparam logic [7:0] SPO_CODE_HV_FAIL  = 8'h86;
    localparam logic [7:0] SPO_CODE_HV_STATE = 8'h87;
endpackage : spo_pkg

// *** shared/spo_pins_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// dedicated flash pin drive bundle from one master
interface spo_pins_if;
    logic sck;   // serial clock
    logic ss_n;  // chip select, active low
    logic mosi;  // data out
    modport src (output sck, output ss_n, output mosi);
    modport dst (input  sck, input  ss_n, input  mosi);
endinterface : spo_pins_if
`default_nettype wire

// *** core/spo_status_enc.sv ***
`timescale 1ns/1ps
`default_nettype none
// priority encoder from fault causes to one 8-bit status code
module spo_status_enc
    import spo_pkg::*;
(
    input  wire logic [SPO_NCAUSE+1:0] cause_i,
    output logic      [7:0]            code_o
);
    import spo_pkg::*;

    // lowest index wins; no cause means success
    always_comb begin
        code_o = SPO_ST_OK;
        if (cause_i[SPO_NCAUSE+1]) begin
            code_o = SPO_CODE_HV_STATE;
        end
        if (cause_i[SPO_NCAUSE]) begin
            code_o = SPO_CODE_HV_FAIL;
        end
        for (int i = SPO_NCAUSE - 1; i >= 0; i--) begin
            if (cause_i[i]) begin
                code_o = SPO_CODE[i];
            end
        end
    end
endmodule : spo_status_enc
`default_nettype wire

// *** core/spo_port_owner.sv ***
`timescale 1ns/1ps
`default_nettype none
// owner of the dedicated flash port plus service status return
module spo_port_owner
    import spo_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // pins
    input  wire logic                  port_en_i,      // enable pin
    input  wire logic                  master_cfg_i,   // port set as master
    input  wire logic                  miso_i,         // flash data in
    output logic                       sck_o,
    output logic                       sck_oe_o,
    output logic                       ss_n_o,
    output logic                       ss_n_oe_o,
    output logic                       mosi_o,
    output logic                       mosi_oe_o,
    // controller side
    input  wire logic                  powerup_done_i,
    input  wire logic                  ctrl_sck_i,
    input  wire logic                  ctrl_ss_n_i,
    input  wire logic                  ctrl_mosi_i,
    input  wire logic                  ctrl_busy_i,    // controller service
    // jtag flash programming
    input  wire logic                  jtag_prog_i,
    input  wire logic                  jtag_sck_i,
    input  wire logic                  jtag_ss_n_i,
    input  wire logic                  jtag_mosi_i,
    // fabric user logic
    input  wire logic                  fab_sck_i,
    input  wire logic                  fab_ss_n_i,
    input  wire logic                  fab_mosi_i,
    input  wire logic                  svc_req_i,      // service request
    input  wire logic                  svc_done_i,     // service complete
    input  wire logic [SPO_NCAUSE+1:0] svc_cause_i,    // fault causes
    output logic                       fab_granted_o,
    output logic                       miso_o,
    output logic [1:0]                 owner_o,
    output logic                       svc_valid_o,    // high the cycle after each svc_done_i cycle
    output logic [7:0]                 svc_status_o
);
    import spo_pkg::*;

    spo_owner_e owner_q;       // current owner
    spo_owner_e owner_d;       // owner wanted
    logic [2:0] en_sync_q;     // enable pin synchroniser
    logic       en_q;          // filtered enable level
    logic [2:0] ss_sync_q;     // chip select from the drive mux
    logic       ss_idle_q;     // mux select deasserted, filtered
    logic [2:0] miso_sync_q;   // flash data synchroniser
    logic       handed_q;      // power-up hand-over done once
    logic       svc_pend_q;    // service holds the port
    logic [7:0] code;          // encoded status
    spo_pins_if mux ();        // selected drive bundle

    // the enable pin is asynchronous: three flops, second and third agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            en_sync_q <= 3'h0;
            en_q      <= 1'b0;
        end else begin
            en_sync_q <= {en_sync_q[1:0], port_en_i};
            if (en_sync_q[1] == en_sync_q[2]) begin
                en_q <= en_sync_q[2];
            end
        end
    end

    // chip select from the drive mux, ahead of the pin register, filtered the same way
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ss_sync_q <= 3'h7;
            ss_idle_q <= 1'b1;
        end else begin
            ss_sync_q <= {ss_sync_q[1:0], mux.ss_n};
            if (ss_sync_q[1] == ss_sync_q[2]) begin
                ss_idle_q <= ss_sync_q[2];
            end
        end
    end

    // flash data back to the fabric, only while it owns the port
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            miso_sync_q <= 3'h0;
            miso_o      <= 1'b0;
        end else begin
            miso_sync_q <= {miso_sync_q[1:0], miso_i};
            if (miso_sync_q[1] == miso_sync_q[2]) begin
                miso_o <= miso_sync_q[2] & (owner_q == SPO_OWN_FAB);
            end
        end
    end

    // a service holds the port from request until its completion
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            svc_pend_q <= 1'b0;
        end else if (svc_req_i) begin
            svc_pend_q <= 1'b1;
        end else if (svc_done_i) begin
            svc_pend_q <= 1'b0;
        end
    end

    // fabric first gets the port once power-up completes in master mode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            handed_q <= 1'b0;
        end else if (powerup_done_i && en_q && master_cfg_i) begin
            handed_q <= 1'b1;
        end
    end

    // owner wanted: jtag, then services, then fabric once handed over
    always_comb begin
        owner_d = SPO_OWN_CTRL;
        if (!en_q) begin
            owner_d = SPO_OWN_NONE;
        end else if (jtag_prog_i) begin
            owner_d = SPO_OWN_JTAG;
        end else if (svc_pend_q || svc_req_i || ctrl_busy_i) begin
            owner_d = SPO_OWN_CTRL;
        end else if (handed_q && master_cfg_i) begin
            owner_d = SPO_OWN_FAB;
        end
    end

    // switch only while the select is idle; disabling acts at once
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            owner_q <= SPO_OWN_NONE;
        end else if (!en_q) begin
            owner_q <= SPO_OWN_NONE;
        end else if (owner_d != owner_q && ss_idle_q && mux.ss_n) begin
            owner_q <= owner_d;
        end
    end

    // only the dedicated pins are muxed; no fabric io is ever touched
    always_comb begin
        mux.sck  = 1'b0;
        mux.ss_n = 1'b1;
        mux.mosi = 1'b0;
        unique case (owner_q)
            SPO_OWN_NONE: begin
                mux.ss_n = 1'b1;
            end
            SPO_OWN_CTRL: begin
                mux.sck  = ctrl_sck_i;
                mux.ss_n = ctrl_ss_n_i;
                mux.mosi = ctrl_mosi_i;
            end
            SPO_OWN_FAB: begin
                // fabric sets its own clock rate
                mux.sck  = fab_sck_i;
                mux.ss_n = fab_ss_n_i;
                mux.mosi = fab_mosi_i;
            end
            SPO_OWN_JTAG: begin
                mux.sck  = jtag_sck_i;
                mux.ss_n = jtag_ss_n_i;
                mux.mosi = jtag_mosi_i;
            end
        endcase
    end

    // registered pin drive; enables low when the port is disabled
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sck_o     <= 1'b0;
            ss_n_o    <= 1'b1;
            mosi_o    <= 1'b0;
            sck_oe_o  <= 1'b0;
            ss_n_oe_o <= 1'b0;
            mosi_oe_o <= 1'b0;
        end else begin
            sck_o     <= mux.sck;
            ss_n_o    <= mux.ss_n;
            mosi_o    <= mux.mosi;
            sck_oe_o  <= en_q && (owner_q != SPO_OWN_NONE);
            ss_n_oe_o <= en_q && (owner_q != SPO_OWN_NONE);
            mosi_oe_o <= en_q && (owner_q != SPO_OWN_NONE);
        end
    end

    // owner visible to user logic
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fab_granted_o <= 1'b0;
            owner_o       <= 2'h0;
        end else begin
            fab_granted_o <= (owner_q == SPO_OWN_FAB);
            owner_o       <= owner_q;
        end
    end

    spo_status_enc u_enc (
        .cause_i (svc_cause_i),
        .code_o  (code)
    );

    // one status per completed service
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            svc_valid_o  <= 1'b0;
            svc_status_o <= SPO_ST_OK;
        end else begin
            svc_valid_o <= svc_done_i;
            if (svc_done_i) begin
                svc_status_o <= code;
            end
        end
    end

    // a completed service always answers the very next cycle
    svc_answer_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        svc_done_i |=> svc_valid_o)
        else $error("service completion without status");

    // clean completion reports zero
    svc_ok_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (svc_done_i && svc_cause_i == '0) |=> svc_status_o == 8'h00)
        else $error("clean service did not report zero");

    // header fault alone gives code 4
    hdr_code_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (svc_done_i && svc_cause_i == 29'h8) |=> svc_status_o == 8'h04)
        else $error("header fault code wrong");

    // trailing data alone gives code 2
    eob_code_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (svc_done_i && svc_cause_i == 29'h2) |=> svc_status_o == 8'h02)
        else $error("trailing data code wrong");

    // abort alone gives 127
    abort_code_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (svc_done_i && svc_cause_i == 29'h100000)
        |=> svc_status_o == 8'h7f)
        else $error("abort code wrong");

    // hv state alone gives 135
    hv_state_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (svc_done_i && svc_cause_i == 29'h10000000)
        |=> svc_status_o == 8'h87)
        else $error("hv state code wrong");

    // status stands until the next completion
    status_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !svc_done_i |=> $stable(svc_status_o))
        else $error("status changed without completion");

    // reserved code never leaves the block
    no_reserved_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        svc_valid_o |-> svc_status_o != 8'h19)
        else $error("reserved status produced");

    // disabled port means no drive two cycles later
    pin_tristate_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !en_q |=> ##1 !sck_oe_o && !ss_n_oe_o && !mosi_oe_o)
        else $error("port driven while disabled");

    // an owned, enabled port is driven on the next cycle
    oe_on_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_q && owner_q != SPO_OWN_NONE)
        |=> sck_oe_o && ss_n_oe_o && mosi_oe_o)
        else $error("owned port not driven");

    // no owner: pins rest at their idle levels
    idle_pins_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(owner_q == SPO_OWN_NONE) |-> ss_n_o && !sck_o && !mosi_o)
        else $error("pins not idle without owner");

    // jtag drive lands on the dedicated pins one cycle later
    jtag_pins_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(owner_q == SPO_OWN_JTAG)
        |-> sck_o == $past(jtag_sck_i) && ss_n_o == $past(jtag_ss_n_i)
            && mosi_o == $past(jtag_mosi_i))
        else $error("jtag drive not on pins");

    // fabric drive lands on the pins one cycle later while it owns them
    fab_pins_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(owner_q == SPO_OWN_FAB)
        |-> sck_o == $past(fab_sck_i) && ss_n_o == $past(fab_ss_n_i)
            && mosi_o == $past(fab_mosi_i))
        else $error("fabric drive not on pins");

    // owner changes only with select idle or on disable
    owner_switch_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (owner_q != $past(owner_q)) |-> ($past(ss_idle_q) || !$past(en_q)))
        else $error("owner changed mid transaction");

    // jtag programming keeps fabric off the port
    jtag_reclaim_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (jtag_prog_i && en_q) |-> owner_d != SPO_OWN_FAB)
        else $error("fabric kept port during jtag programming");

    // jtag takes the port at the first idle select
    jtag_take_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_q && jtag_prog_i && ss_idle_q && mux.ss_n)
        |=> owner_q == SPO_OWN_JTAG)
        else $error("jtag did not take the port");

    // a service takes the port back at the first idle select
    svc_take_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_q && !jtag_prog_i && (svc_pend_q || svc_req_i) && ss_idle_q
            && mux.ss_n) |=> owner_q == SPO_OWN_CTRL)
        else $error("service did not reclaim the port");

    // a request always marks the service pending
    svc_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        svc_req_i |=> svc_pend_q)
        else $error("service request lost");

    // fabric only owns after the hand-over
    fab_after_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        owner_q == SPO_OWN_FAB |-> handed_q)
        else $error("fabric owns before hand-over");

    // hand-over latches once power-up ends in master mode
    handover_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (powerup_done_i && en_q && master_cfg_i) |=> handed_q)
        else $error("hand-over not latched");

    // with no other claim the fabric gets the port at idle select
    fab_take_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_q && handed_q && master_cfg_i && !jtag_prog_i && !ctrl_busy_i
            && !svc_pend_q && !svc_req_i && ss_idle_q && mux.ss_n)
        |=> owner_q == SPO_OWN_FAB)
        else $error("fabric not given the port");

    // granted flag mirrors fabric ownership one cycle late
    grant_flag_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        fab_granted_o == ($past(owner_q) == SPO_OWN_FAB))
        else $error("grant flag out of step with owner");
endmodule : spo_port_owner
`default_nettype wire

// *** bench/spo_fab_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// fabric-side serial master; starts a frame only while the port is granted
module spo_fab_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,      // ask for one frame
    input  wire logic       granted_i, // port released to fabric
    input  wire logic [3:0] div_i,     // half period of sck in clocks
    output logic            sck_o,
    output logic            ss_n_o,
    output logic            mosi_o,
    output logic            busy_o     // frame in progress
);
    // one byte per frame; sck stands still between frames
    initial begin
        sck_o  = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i && granted_i) begin
                @(negedge clk_i);
                busy_o = 1'b1;
                ss_n_o = 1'b0;
                for (int b = 0; b < 8; b++) begin
                    mosi_o = b[0];
                    repeat (div_i) @(negedge clk_i);
                    sck_o = 1'b1;
                    repeat (div_i) @(negedge clk_i);
                    sck_o = 1'b0;
                end
                ss_n_o = 1'b1;
                // released data line must not keep the last bit
                mosi_o = ~mosi_o;
                busy_o = 1'b0;
            end
        end
    end
endmodule : spo_fab_model
`default_nettype wire

// *** bench/spi_port_owner_and_service_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_port_owner_and_service_status_tb;
    import spo_pkg::*;
    // stimulus toward the block
    logic clk_i, rst_n_i, port_en_i, master_cfg_i, miso_i, powerup_done_i;
    logic ctrl_sck_i, ctrl_ss_n_i, ctrl_mosi_i, ctrl_busy_i, svc_req_i;
    logic jtag_prog_i, jtag_sck_i, jtag_ss_n_i, jtag_mosi_i, svc_done_i;
    logic fab_sck_i, fab_ss_n_i, fab_mosi_i, fab_go, fab_busy, bad;
    logic [SPO_NCAUSE+1:0] svc_cause_i;
    // observed outputs
    logic sck_o, sck_oe_o, ss_n_o, ss_n_oe_o, mosi_o, mosi_oe_o;
    logic       fab_granted_o, miso_o, svc_valid_o;
    logic [1:0] owner_o;
    logic [7:0] svc_status_o;
    logic [7:0] exp_q [$];  // expected status, oldest first
    int         n_mismatch = 0;
    int         n_tests = 0;
    int         seed = 82;
    int         r, rr;
    logic       miso_hold = 1'b0; // flash data held still for a check
    logic       miso_fix = 1'b0;  // level held while miso_hold is set
    // status code for each cause bit alone
    logic [7:0] code_tab [29] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
        8'h15, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h1b, 8'h7f, 8'h80, 8'h81,
        8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};

    initial clk_i = 1'b0;
    // 40 mhz
    always #12.5 clk_i = ~clk_i;

    spo_port_owner dut (
        .clk_i, .rst_n_i, .port_en_i, .master_cfg_i, .miso_i, .sck_o,
        .sck_oe_o, .ss_n_o, .ss_n_oe_o, .mosi_o, .mosi_oe_o,
        .powerup_done_i, .ctrl_sck_i, .ctrl_ss_n_i, .ctrl_mosi_i,
        .ctrl_busy_i, .jtag_prog_i, .jtag_sck_i, .jtag_ss_n_i,
        .jtag_mosi_i, .fab_sck_i, .fab_ss_n_i, .fab_mosi_i, .svc_req_i,
        .svc_done_i, .svc_cause_i, .fab_granted_o, .miso_o, .owner_o,
        .svc_valid_o, .svc_status_o
    );

    spo_fab_model fab (
        .clk_i(clk_i), .go_i(fab_go), .granted_i(fab_granted_o),
        .div_i(4'h2), .sck_o(fab_sck_i), .ss_n_o(fab_ss_n_i),
        .mosi_o(fab_mosi_i), .busy_o(fab_busy)
    );

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait for an owner, then compare
    task wait_owner(input logic [1:0] w);
        for (int k = 0; k < 40 && owner_o !== w; k++) @(negedge clk_i);
        chk(owner_o, w);
    endtask : wait_owner

    // lowest set cause bit decides the code
    function automatic logic [7:0] exp_code(input logic [28:0] c);
        for (int i = 0; i < 29; i++) if (c[i] === 1'b1) return code_tab[i];
        return 8'h00;
    endfunction : exp_code

    task wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // each status pulse against the oldest note
    always @(negedge clk_i) begin
        if (svc_valid_o === 1'b1) begin
            if (exp_q.size() == 0) chk(8'h00, 8'hff);
            else chk(svc_status_o, exp_q.pop_front());
        end
    end

    // controller clock and data lines and flash data wander at random
    always @(negedge clk_i) begin
        rr = $random(seed);
        miso_i = miso_hold ? miso_fix : rr[0];
        ctrl_sck_i = rr[1];
        ctrl_mosi_i = rr[2];
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("Error at %0t: timeout", $time);
        wrap_up;
    end

    initial begin
        {rst_n_i, powerup_done_i, ctrl_busy_i, svc_req_i, svc_done_i} = '0;
        {jtag_prog_i, jtag_sck_i, jtag_mosi_i, fab_go} = '0;
        {port_en_i, master_cfg_i, ctrl_ss_n_i, jtag_ss_n_i} = '1;
        svc_cause_i = '0;
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        // no hand-over before power-up completes
        repeat (8) @(negedge clk_i);
        chk(fab_granted_o, 1'b0);
        powerup_done_i = 1'b1;
        wait_owner(SPO_OWN_FAB);
        chk(fab_granted_o, 1'b1);
        // a service request in mid-frame waits for select idle
        fab_go = 1'b1;
        for (int k = 0; k < 8 && fab_busy !== 1'b1; k++) @(negedge clk_i);
        fab_go = 1'b0;
        svc_req_i = 1'b1;
        @(negedge clk_i);
        svc_req_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk(ss_n_o, 1'b0);
        bad = 1'b0;
        while (fab_busy === 1'b1) begin
            if (owner_o !== SPO_OWN_FAB) bad = 1'b1;
            @(negedge clk_i);
        end
        chk(bad, 1'b0);
        wait_owner(SPO_OWN_CTRL);
        chk(fab_granted_o, 1'b0);
        // completion returns the port to the fabric
        svc_done_i = 1'b1;
        exp_q.push_back(8'h00);
        @(negedge clk_i);
        svc_done_i = 1'b0;
        wait_owner(SPO_OWN_FAB);
        // every cause alone, back to back, then mixed causes
        for (int i = 0; i < 29; i++) begin
            svc_cause_i = '0;
            svc_cause_i[i] = 1'b1;
            svc_done_i = 1'b1;
            exp_q.push_back(exp_code(svc_cause_i));
            @(negedge clk_i);
        end
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            svc_cause_i = r[28:0] >> r[31:27];
            exp_q.push_back(exp_code(svc_cause_i));
            @(negedge clk_i);
        end
        svc_cause_i = 29'h18000000;
        exp_q.push_back(8'h86);
        @(negedge clk_i);
        svc_done_i = 1'b0;
        // jtag programming claims the port; pins follow its drive
        {jtag_prog_i, jtag_sck_i} = 2'b11;
        wait_owner(SPO_OWN_JTAG);
        repeat (2) @(negedge clk_i);
        chk({sck_o, ss_n_o, mosi_o}, 8'h06);
        {jtag_ss_n_i, jtag_mosi_i} = 2'b01;
        repeat (2) @(negedge clk_i);
        chk({sck_o, ss_n_o, mosi_o}, 8'h05);
        // no switch while jtag holds select low
        jtag_prog_i = 1'b0;
        repeat (5) @(negedge clk_i);
        chk(owner_o, SPO_OWN_JTAG);
        jtag_ss_n_i = 1'b1;
        wait_owner(SPO_OWN_FAB);
        ctrl_busy_i = 1'b1;
        wait_owner(SPO_OWN_CTRL);
        ctrl_busy_i = 1'b0;
        wait_owner(SPO_OWN_FAB);
        // flash data reaches the fabric only while it owns the port
        miso_fix = 1'b1;
        miso_hold = 1'b1;
        repeat (6) @(negedge clk_i);
        chk(miso_o, 1'b1);
        chk({sck_oe_o, ss_n_oe_o, mosi_oe_o}, 8'h07);
        // disabled port drives nothing
        port_en_i = 1'b0;
        wait_owner(SPO_OWN_NONE);
        chk({sck_oe_o, ss_n_oe_o, mosi_oe_o}, 8'h00);
        chk(miso_o, 1'b0);
        port_en_i = 1'b1;
        wait_owner(SPO_OWN_FAB);
        repeat (4) @(negedge clk_i);
        chk(exp_q.size(), 8'h00);
        wrap_up;
    end
endmodule : spi_port_owner_and_service_status_tb
`default_nettype wire
